// [core/phy_cfg.svh]
/*
  Constants for the sleep/wake and address/quality configuration registers:
  register offsets, field positions, reset values and the wake activation count.
  Assumes a 200 MHz core clock and a 5-bit management register address.
*/
//
// Behaviour
// - Sleep acknowledge bit 0: timer off, data activity returns Sleep Request to Normal.
// - Remote wake forward bit chooses whether detected remote wake events go onward.
// - Auto transition bit, default 1, lets a sleep code group start Sleep Request.
// - Wake react and forward enables reset to strap input values, not constants.
// - Local wake events within activation time after enabling may be dropped.
// - Address field reads 00, two strap bits, then 0.
// - Averaging field picks 32, 64 (default), 128 or 256 symbols.
// - Warning threshold: 000 disables, 001 to 111 classes A to G, default 001.
// - Fail threshold: 000 (default) none, 001 to 111 classes A to G.
// - Jumbo bit: 0 limits packets to 4 kB, 1 (default) allows 16 kB.
// - Latched warning event when quality drops below warning class while link up.
`ifndef PHY_CFG_SVH
`define PHY_CFG_SVH

`define SLEEP_WAKE_OFFSET     5'h12
`define ADDR_QUAL_OFFSET      5'h13

`define LOC_FWD_BIT           14
`define REM_REACT_BIT         11
`define LOC_REACT_BIT         10
`define SYM_DIS_BIT           5
`define SLEEP_ACK_BIT         4
`define REM_FWD_BIT           2
`define AUTONOMOUS_POWER_DOWN_ENABLE_BIT          1
`define AUTO_TRANS_BIT        0

`define ADDR_MSB              15
`define ADDR_LSB              11
`define AVG_MSB               10
`define AVG_LSB               9
`define WLIM_MSB              8
`define WLIM_LSB              6
`define FLIM_MSB              5
`define FLIM_LSB              3
`define JUMBO_BIT             2

`define SYM_DIS_RST           1'b0
`define SLEEP_ACK_RST         1'b0
`define AUTONOMOUS_POWER_DOWN_ENABLE_RST          1'b0
`define AUTO_TRANS_RST        1'b1
`define AVG_RST               2'h1
`define WLIM_RST              3'h1
`define FLIM_RST              3'h0
`define JUMBO_RST             1'b1

`define MIN_AVG_SYMBOLS       9'h020
`define SMALL_PKT_KB          5'h04
`define JUMBO_PKT_KB          5'h10

`define WAKE_ACT_TIME_NS      1000
`define CLK_PERIOD_NS         5
`define WAKE_ACT_CYCLES       ((`WAKE_ACT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [core/phy_cfg_pkg.sv]
/*
  Types for the configuration register block: phase of strap capture
  and the packed state of the block. Assumes phy_cfg.svh is not needed here.
*/
package phy_cfg_pkg;

  typedef enum logic [0:0] {PH_STRAP, PH_RUN} phase_type;

  typedef struct packed {
    phase_type   phase;
    logic        loc_fwd;
    logic        rem_react;
    logic        loc_react;
    logic        sym_dis;
    logic        sleep_ack;
    logic        rem_fwd;
    logic        autonomous_power_down_enable;
    logic        auto_trans;
    logic [1:0]  addr_strap;
    logic [1:0]  avg;
    logic [2:0]  wlim;
    logic [2:0]  flim;
    logic        jumbo;
    logic [15:0] rdata;
    logic        rvalid;
    logic [11:0] act_cnt;
    logic        warn_evt;
    logic        fail;
    logic        auto_sleep;
    logic        ret_normal;
    logic        rem_out;
    logic        loc_out;
  } state_type;

endpackage

// [core/phy_sleep_wake_sqi_config.sv]
/*
  Sleep/wake configuration and address/quality configuration registers of the
  PHY, with the small amount of logic that these settings steer directly.
  Assumes a register port from the management interface decoder, sampled on
  MCLK, and strap pins stable around reset release.
*/
`timescale 1ns/1ps
`include "phy_cfg.svh"

module phy_sleep_wake_sqi_config
  import phy_cfg_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  output logic             REG_RVALID,
  input  wire logic [1:0]  STRAP_ADDR,
  input  wire logic [3:0]  STRAP_WAKE,
  input  wire logic        SLEEP_CODE_RX,
  input  wire logic        IN_SLEEP_REQUEST,
  input  wire logic        MEDIA_ACTIVE,
  input  wire logic        REMOTE_WAKE_DET,
  input  wire logic        LOCAL_WAKE_DET,
  input  wire logic [2:0]  QUALITY_VALUE,
  input  wire logic        LINK_UP,
  input  wire logic        WARN_CLR,
  output logic             SLEEP_ACK_TIMER_EN,
  output logic             RETURN_TO_NORMAL,
  output logic             AUTO_SLEEP_REQ,
  output logic             REMOTE_WAKE_FWD,
  output logic             LOCAL_WAKE_FWD,
  output logic             LOCAL_WAKE_REACT,
  output logic             REMOTE_WAKE_REACT,
  output logic             AUTONOMOUS_POWER_DOWN_ENABLE_EN,
  output logic             WAKE_SYMBOL_DIS,
  output logic      [4:0]  PHY_ADDR,
  output logic      [8:0]  AVG_SYMBOLS,
  output logic      [2:0]  WARN_LIMIT,
  output logic      [2:0]  FAIL_LIMIT,
  output logic             QUALITY_FAIL,
  output logic             QUALITY_WARNING_EVENT,
  output logic             JUMBO_EN,
  output logic      [4:0]  MAX_PKT_KB
);
  import phy_cfg_pkg::*;

  localparam logic [11:0] ACT_CYCLES = 12'(`WAKE_ACT_CYCLES);

  state_type s_q;
  state_type s_d;

  // Class code n flags a quality value below n; code 0 never flags
  function automatic logic below_limit(input logic [2:0] limit, input logic [2:0] value);
    below_limit = (limit != 3'h0) && (value < limit);
  endfunction

  function automatic logic [15:0] sleep_wake_word(input state_type s);
    logic [15:0] w;
    w = 16'h0000;
    w[`LOC_FWD_BIT]    = s.loc_fwd;
    w[`REM_REACT_BIT]  = s.rem_react;
    w[`LOC_REACT_BIT]  = s.loc_react;
    w[`SYM_DIS_BIT]    = s.sym_dis;
    w[`SLEEP_ACK_BIT]  = s.sleep_ack;
    w[`REM_FWD_BIT]    = s.rem_fwd;
    w[`AUTONOMOUS_POWER_DOWN_ENABLE_BIT]   = s.autonomous_power_down_enable;
    w[`AUTO_TRANS_BIT] = s.auto_trans;
    sleep_wake_word = w;
  endfunction

  function automatic logic [4:0] phy_address(input logic [1:0] strap);
    phy_address = {2'h0, strap, 1'b0};
  endfunction

  logic wr_sw;
  logic wr_aq;
  logic loc_accept;

  assign wr_sw = REG_WR && (REG_ADDR == `SLEEP_WAKE_OFFSET) && (s_q.phase == PH_RUN);
  assign wr_aq = REG_WR && (REG_ADDR == `ADDR_QUAL_OFFSET) && (s_q.phase == PH_RUN);
  assign loc_accept = LOCAL_WAKE_DET && s_q.loc_react && (s_q.act_cnt == 12'h000);

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.auto_sleep = 1'b0;
    s_d.rem_out = 1'b0;
    s_d.loc_out = 1'b0;

    unique case (s_q.phase)
      PH_STRAP: begin
        s_d.loc_fwd    = STRAP_WAKE[3];
        s_d.rem_react  = STRAP_WAKE[2];
        s_d.loc_react  = STRAP_WAKE[1];
        s_d.rem_fwd    = STRAP_WAKE[0];
        s_d.addr_strap = STRAP_ADDR;
        s_d.phase      = PH_RUN;
      end
      PH_RUN: begin
        if (wr_sw) begin
          // Reserved bits are dropped on write so they always read zero
          s_d.loc_fwd    = REG_WDATA[`LOC_FWD_BIT];
          s_d.rem_react  = REG_WDATA[`REM_REACT_BIT];
          s_d.loc_react  = REG_WDATA[`LOC_REACT_BIT];
          s_d.sym_dis    = REG_WDATA[`SYM_DIS_BIT];
          s_d.sleep_ack  = REG_WDATA[`SLEEP_ACK_BIT];
          s_d.rem_fwd    = REG_WDATA[`REM_FWD_BIT];
          s_d.autonomous_power_down_enable   = REG_WDATA[`AUTONOMOUS_POWER_DOWN_ENABLE_BIT];
          s_d.auto_trans = REG_WDATA[`AUTO_TRANS_BIT];
        end
        if (wr_aq) begin
          s_d.avg  = REG_WDATA[`AVG_MSB:`AVG_LSB];
          s_d.wlim = REG_WDATA[`WLIM_MSB:`WLIM_LSB];
          s_d.flim = REG_WDATA[`FLIM_MSB:`FLIM_LSB];
          s_d.jumbo = REG_WDATA[`JUMBO_BIT];
        end
      end
    endcase

    if (wr_sw && REG_WDATA[`LOC_REACT_BIT] && !s_q.loc_react) begin
      s_d.act_cnt = ACT_CYCLES;
    end else if (s_q.act_cnt != 12'h000) begin
      s_d.act_cnt = s_q.act_cnt - 12'h001;
    end

    if (REG_RD) begin
      s_d.rvalid = 1'b1;
      if (REG_ADDR == `SLEEP_WAKE_OFFSET) begin
        s_d.rdata = sleep_wake_word(s_q);
      end else if (REG_ADDR == `ADDR_QUAL_OFFSET) begin
        s_d.rdata = {phy_address(s_q.addr_strap), s_q.avg, s_q.wlim, s_q.flim,
                     s_q.jumbo, 2'h0};
      end else begin
        s_d.rdata = 16'h0000;
      end
    end

    s_d.auto_sleep = SLEEP_CODE_RX && s_q.auto_trans && (s_q.phase == PH_RUN);
    s_d.ret_normal = IN_SLEEP_REQUEST && MEDIA_ACTIVE && !s_q.sleep_ack;
    s_d.rem_out = REMOTE_WAKE_DET && s_q.rem_fwd && (s_q.phase == PH_RUN);
    s_d.loc_out = loc_accept && s_q.loc_fwd;

    s_d.fail = LINK_UP && below_limit(s_q.flim, QUALITY_VALUE);
    // latched warning, set wins over clear
    if (LINK_UP && below_limit(s_q.wlim, QUALITY_VALUE)) begin
      s_d.warn_evt = 1'b1;
    end else if (WARN_CLR) begin
      s_d.warn_evt = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '{phase: PH_STRAP, sym_dis: `SYM_DIS_RST, sleep_ack: `SLEEP_ACK_RST,
               autonomous_power_down_enable: `AUTONOMOUS_POWER_DOWN_ENABLE_RST, auto_trans: `AUTO_TRANS_RST, avg: `AVG_RST,
               wlim: `WLIM_RST, flim: `FLIM_RST, jumbo: `JUMBO_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA          = s_q.rdata;
  assign REG_RVALID         = s_q.rvalid;
  assign SLEEP_ACK_TIMER_EN = s_q.sleep_ack;
  assign RETURN_TO_NORMAL   = s_q.ret_normal;
  assign AUTO_SLEEP_REQ     = s_q.auto_sleep;
  assign REMOTE_WAKE_FWD    = s_q.rem_out;
  assign LOCAL_WAKE_FWD     = s_q.loc_out;
  assign LOCAL_WAKE_REACT   = s_q.loc_react;
  assign REMOTE_WAKE_REACT  = s_q.rem_react;
  assign AUTONOMOUS_POWER_DOWN_ENABLE_EN        = s_q.autonomous_power_down_enable;
  assign WAKE_SYMBOL_DIS    = s_q.sym_dis;
  assign PHY_ADDR           = phy_address(s_q.addr_strap);
  assign AVG_SYMBOLS        = `MIN_AVG_SYMBOLS << s_q.avg;
  assign WARN_LIMIT         = s_q.wlim;
  assign FAIL_LIMIT         = s_q.flim;
  assign QUALITY_FAIL       = s_q.fail;
  assign QUALITY_WARNING_EVENT = s_q.warn_evt;
  assign JUMBO_EN           = s_q.jumbo;
  assign MAX_PKT_KB         = s_q.jumbo ? `JUMBO_PKT_KB : `SMALL_PKT_KB;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  chk_sleep_ack_return: assert property (
    IN_SLEEP_REQUEST && MEDIA_ACTIVE && !SLEEP_ACK_TIMER_EN |=> RETURN_TO_NORMAL)
    else $error("return to normal missing while timer off");

  chk_ack_blocks_return: assert property (
    SLEEP_ACK_TIMER_EN && $stable(SLEEP_ACK_TIMER_EN) |=> !RETURN_TO_NORMAL)
    else $error("return to normal while sleep ack timer on");

  chk_remote_fwd_gate: assert property (
    REMOTE_WAKE_FWD |-> $past(REMOTE_WAKE_DET) && $past(s_q.rem_fwd))
    else $error("remote wake forwarded while forwarding off");

  chk_auto_sleep_req: assert property (
    $past(s_q.phase) == PH_RUN && $past(SLEEP_CODE_RX) |->
      AUTO_SLEEP_REQ == $past(s_q.auto_trans))
    else $error("sleep code transition does not follow enable");

  chk_strap_load: assert property (
    s_q.phase == PH_STRAP |=> REMOTE_WAKE_REACT == $past(STRAP_WAKE[2]) &&
      LOCAL_WAKE_REACT == $past(STRAP_WAKE[1]))
    else $error("wake enables not taken from straps");

  chk_wake_blanking: assert property (
    wr_sw && REG_WDATA[`LOC_REACT_BIT] && !s_q.loc_react && REG_WDATA[`LOC_FWD_BIT]
      |=> (!LOCAL_WAKE_FWD) [*8])
    else $error("local wake forwarded inside activation time");

  chk_address_form: assert property (
    PHY_ADDR[4:3] == 2'h0 && PHY_ADDR[0] == 1'b0)
    else $error("phy address fixed bits wrong");

  chk_avg_length: assert property (
    s_q.avg == 2'h3 |-> AVG_SYMBOLS == 9'h100)
    else $error("averaging length wrong for code 11");

  chk_warn_latch: assert property (
    LINK_UP && s_q.wlim != 3'h0 && QUALITY_VALUE < s_q.wlim
      |=> QUALITY_WARNING_EVENT ##1 (QUALITY_WARNING_EVENT || $past(WARN_CLR)))
    else $error("quality warning not latched");

  chk_fail_off: assert property (
    FAIL_LIMIT == 3'h0 |=> !QUALITY_FAIL)
    else $error("fail raised with no fail limit");

  chk_jumbo_len: assert property (
    !JUMBO_EN |-> MAX_PKT_KB == 5'h04)
    else $error("packet limit wrong with jumbo off");

  chk_jumbo_len_on: assert property (
    JUMBO_EN |-> MAX_PKT_KB == 5'h10)
    else $error("packet limit wrong with jumbo on");

  chk_avg_short: assert property (
    s_q.avg == 2'h0 |-> AVG_SYMBOLS == 9'h020)
    else $error("averaging length wrong for code 00");

  chk_avg_default: assert property (
    s_q.avg == 2'h1 |-> AVG_SYMBOLS == 9'h040)
    else $error("averaging length wrong for code 01");

  chk_avg_double: assert property (
    s_q.avg == 2'h2 |-> AVG_SYMBOLS == 9'h080)
    else $error("averaging length wrong for code 10");

  chk_address_strap: assert property (
    s_q.phase == PH_STRAP |=> PHY_ADDR == {2'h0, $past(STRAP_ADDR), 1'b0})
    else $error("phy address not taken from straps");

  chk_return_idle: assert property (
    !(IN_SLEEP_REQUEST && MEDIA_ACTIVE) |=> !RETURN_TO_NORMAL)
    else $error("return to normal without sleep request activity");

  chk_auto_sleep_idle: assert property (
    !SLEEP_CODE_RX |=> !AUTO_SLEEP_REQ)
    else $error("sleep request with no sleep code");

  chk_remote_fwd_on: assert property (
    REMOTE_WAKE_DET && s_q.rem_fwd |=> REMOTE_WAKE_FWD)
    else $error("remote wake not forwarded while forwarding on");

  chk_local_fwd_gate: assert property (
    LOCAL_WAKE_FWD |-> $past(LOCAL_WAKE_DET) && $past(LOCAL_WAKE_REACT) &&
      $past(s_q.loc_fwd))
    else $error("local wake forwarded without enables");

  chk_act_load: assert property (
    wr_sw && REG_WDATA[`LOC_REACT_BIT] && !s_q.loc_react |=> s_q.act_cnt == ACT_CYCLES)
    else $error("wake activation time not started");

  chk_act_blocks: assert property (
    s_q.act_cnt != 12'h000 |=> !LOCAL_WAKE_FWD)
    else $error("local wake forwarded while activation time runs");

  chk_fail_level: assert property (
    LINK_UP && FAIL_LIMIT != 3'h0 && QUALITY_VALUE < FAIL_LIMIT |=> QUALITY_FAIL)
    else $error("fail not raised below fail limit");

  chk_fail_nolink: assert property (
    !LINK_UP |=> !QUALITY_FAIL)
    else $error("fail raised with link down");

  chk_warn_off: assert property (
    WARN_LIMIT == 3'h0 && !QUALITY_WARNING_EVENT |=> !QUALITY_WARNING_EVENT)
    else $error("warning raised with no warning limit");

  chk_warn_nolink: assert property (
    !LINK_UP && !QUALITY_WARNING_EVENT |=> !QUALITY_WARNING_EVENT)
    else $error("warning raised with link down");

  chk_warn_hold: assert property (
    QUALITY_WARNING_EVENT && !WARN_CLR |=> QUALITY_WARNING_EVENT)
    else $error("warning dropped without clear");

  chk_warn_clear: assert property (
    QUALITY_WARNING_EVENT && WARN_CLR &&
      !(LINK_UP && WARN_LIMIT != 3'h0 && QUALITY_VALUE < WARN_LIMIT)
      |=> !QUALITY_WARNING_EVENT)
    else $error("warning not cleared");

endmodule

// [verif/mgmt_master_model.sv]
/*
  Management controller model that reaches the two configuration registers.
  Assumes the block answers a read with a one-cycle valid after the strobe.
*/
`timescale 1ns/1ps
module mgmt_master_model (
  input  wire logic        MCLK,
  output logic      [4:0]  REG_ADDR,
  output logic             REG_WR,
  output logic             REG_RD,
  output logic      [15:0] REG_WDATA,
  input  wire logic [15:0] REG_RDATA,
  input  wire logic        REG_RVALID
);
  logic [15:0] rd_word;
  initial begin
    REG_ADDR = 5'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = 16'h0000;
  end
  function automatic logic [15:0] legal(input logic [4:0] a, input logic [15:0] d);
    legal = (a == 5'h12) ? (d & 16'h4c37) : (d & 16'hfffc);
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge MCLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = legal(a, d);
    REG_WR = 1'b1;
    @(posedge MCLK);
    #1;
    REG_WR = 1'b0;
    // Released data wiggles so a stale sample cannot pass
    REG_WDATA = ~REG_WDATA;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge MCLK);
    #1;
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(posedge MCLK);
    #1;
    REG_RD = 1'b0;
    rd_word = (REG_RVALID === 1'b1) ? REG_RDATA : 16'hxxxx;
  endtask
endmodule

// [verif/phy_sleep_wake_sqi_config_tb.sv]
/*
  Self-checking bench for the configuration registers.
  Assumes the management model drives the register port.
*/
`timescale 1ns/1ps
`include "phy_cfg.svh"
module phy_sleep_wake_sqi_config_tb;
  typedef struct packed {
    logic [15:0] wd;
    logic [8:0]  avg;
    logic [4:0]  kb;
    logic        fl;
  } row_type;
  logic        mclk, rst_n, rd, wr, in_sr, media, link, wclr;
  logic [2:0]  ev, qv, wlim, flim;
  logic [4:0]  addr, phy_addr, kb;
  logic [1:0]  saddr;
  logic [3:0]  swake;
  logic [15:0] wdata, rdata;
  logic [8:0]  avg;
  logic        rv, ack, rtn, asr, rfw, lfw, lre, rre, apd, sdis, qf, qw, jmb;
  int          err_total, total_checks;
  row_type     rows [8];
  mgmt_master_model u_mgmt_master_model (.MCLK(mclk), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rv));
  phy_sleep_wake_sqi_config u_phy_sleep_wake_sqi_config (.MCLK(mclk), .RST_N(rst_n),
    .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rv), .STRAP_ADDR(saddr), .STRAP_WAKE(swake), .SLEEP_CODE_RX(ev[2]),
    .IN_SLEEP_REQUEST(in_sr), .MEDIA_ACTIVE(media), .REMOTE_WAKE_DET(ev[1]),
    .LOCAL_WAKE_DET(ev[0]), .QUALITY_VALUE(qv), .LINK_UP(link), .WARN_CLR(wclr),
    .SLEEP_ACK_TIMER_EN(ack), .RETURN_TO_NORMAL(rtn), .AUTO_SLEEP_REQ(asr),
    .REMOTE_WAKE_FWD(rfw), .LOCAL_WAKE_FWD(lfw), .LOCAL_WAKE_REACT(lre),
    .REMOTE_WAKE_REACT(rre), .AUTONOMOUS_POWER_DOWN_ENABLE_EN(apd), .WAKE_SYMBOL_DIS(sdis),
    .PHY_ADDR(phy_addr), .AVG_SYMBOLS(avg), .WARN_LIMIT(wlim), .FAIL_LIMIT(flim),
    .QUALITY_FAIL(qf), .QUALITY_WARNING_EVENT(qw), .JUMBO_EN(jmb), .MAX_PKT_KB(kb));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic fire(input logic [2:0] v);
    @(posedge mclk);
    #1 ev = v;
    @(posedge mclk);
    #1 ev = 3'h0;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    // Quality value 3 fails against classes 4 to 7 only
    rows = '{'{16'h0038, 9'd32, 5'd4, 1'b1}, '{16'h0274, 9'd64, 5'd16, 1'b1},
             '{16'h04a8, 9'd128, 5'd4, 1'b1}, '{16'h06e4, 9'd256, 5'd16, 1'b1},
             '{16'h0118, 9'd32, 5'd4, 1'b0}, '{16'h0354, 9'd64, 5'd16, 1'b0},
             '{16'h0588, 9'd128, 5'd4, 1'b0}, '{16'h07c4, 9'd256, 5'd16, 1'b0}};
    {rst_n, ev, in_sr, media, wclr} = '0;
    {saddr, swake} = 6'b10_1011;
    qv = 3'h3;
    link = 1'b1;
    waitc(3);
    chk("avg_rst", 16'd64, avg);
    chk("wlim_rst", 16'h1, wlim);
    chk("kb_rst", 16'd16, kb);
    waitc(2);
    rst_n = 1'b1;
    waitc(2);
    chk("phy_addr", 16'h04, phy_addr);
    chk("react", 16'h1, {rre, lre});
    u_mgmt_master_model.rd(`SLEEP_WAKE_OFFSET);
    chk("reg18_rst", 16'h4405, u_mgmt_master_model.rd_word);
    u_mgmt_master_model.rd(`ADDR_QUAL_OFFSET);
    chk("reg19_rst", 16'h2244, u_mgmt_master_model.rd_word);
    for (int i = 0; i < 8; i++) begin
      u_mgmt_master_model.wr(`ADDR_QUAL_OFFSET, rows[i].wd | 16'hf800);
      u_mgmt_master_model.rd(`ADDR_QUAL_OFFSET);
      chk("avg", rows[i].avg, avg);
      chk("wlim", rows[i].wd[8:6], wlim);
      chk("flim", rows[i].wd[5:3], flim);
      chk("fail", rows[i].fl, qf);
      chk("kb", rows[i].kb, kb);
      chk("jumbo", rows[i].wd[2], jmb);
      chk("reg19", rows[i].wd | 16'h2000, u_mgmt_master_model.rd_word);
    end
    {in_sr, media} = 2'b11;
    u_mgmt_master_model.wr(`SLEEP_WAKE_OFFSET, 16'h0000);
    fire(3'h7);
    chk("ev_off", 16'h0, {asr, rfw, lfw, ack, lre});
    chk("rtn_on", 16'h1, rtn);
    u_mgmt_master_model.wr(`SLEEP_WAKE_OFFSET, 16'h4437);
    fire(3'h7);
    chk("ev_on", 16'h6, {asr, rfw, lfw});
    chk("flags", 16'h7, {ack, apd, sdis});
    chk("rtn_off", 16'h0, rtn);
    waitc(`WAKE_ACT_CYCLES);
    fire(3'h1);
    chk("loc_fwd", 16'h1, {asr, lfw});
    u_mgmt_master_model.rd(`SLEEP_WAKE_OFFSET);
    chk("reg18", 16'h4437, u_mgmt_master_model.rd_word);
    u_mgmt_master_model.rd(5'h14);
    chk("unmapped", 16'h0, u_mgmt_master_model.rd_word);
    // Warning stays latched and clear loses to a live condition
    {link, qv, wclr} = 5'b0_111_1;
    waitc(2);
    {qv, wclr} = 4'b011_0;
    waitc(2);
    chk("warn_nolink", 16'h0, qw);
    link = 1'b1;
    waitc(2);
    wclr = 1'b1;
    waitc(2);
    chk("warn_set", 16'h1, qw);
    {qv, wclr} = 4'b111_0;
    waitc(2);
    chk("warn_held", 16'h1, qw);
    wclr = 1'b1;
    waitc(2);
    chk("warn_clr", 16'h0, qw);
    // Reset again mid-run with other straps; enables and address must follow them
    {saddr, swake} = 6'b01_0100;
    rst_n = 1'b0;
    waitc(2);
    chk("warn_rst", 16'h0, qw);
    chk("ack_rst", 16'h0, ack);
    rst_n = 1'b1;
    waitc(2);
    chk("phy_addr2", 16'h02, phy_addr);
    chk("react2", 16'h2, {rre, lre});
    u_mgmt_master_model.rd(`SLEEP_WAKE_OFFSET);
    chk("reg18_rst2", 16'h0801, u_mgmt_master_model.rd_word);
    u_mgmt_master_model.rd(`ADDR_QUAL_OFFSET);
    chk("reg19_rst2", 16'h1244, u_mgmt_master_model.rd_word);
    tally_and_finish();
  end
endmodule
